//--- rbc_pkg.sv
// constants and types for the reset and bootstrap configuration block
// assumes one 50 MHz reference clock and an active-low async reset
package rbc_pkg;

  // test mode selector codes
  typedef enum logic [1:0] {
    MODE_PLL    = 2'h0,
    MODE_SCAN   = 2'h1,
    MODE_BOARD  = 2'h2,
    MODE_NORMAL = 2'h3
  } tmode_e;

  // power-up sequence, gray coded along the path
  typedef enum logic [1:0] {
    SEQ_WAIT   = 2'h0,
    SEQ_SAMPLE = 2'h1,
    SEQ_HOLD   = 2'h3,
    SEQ_RUN    = 2'h2
  } seq_e;

  // widths
  localparam int unsigned TD_W   = 16;
  localparam int unsigned HOLD_W = 15;
  localparam int unsigned LANES  = 4;

  // post-reset core hold counts
  localparam logic [14:0] HOLD_LONG  = 15'h3fdc;
  localparam logic [14:0] HOLD_SHORT = 15'h0100;

  // wait-state count after reset release; straps are captured on the sixth clock edge after release
  localparam logic [2:0] STRAP_DLY = 3'h4;

  // strap bit positions on the test bus
  localparam int unsigned STRAP_BOARD_SEL = 10;
  localparam int unsigned STRAP_CDLY_HI   = 10;
  localparam int unsigned STRAP_CDLY_LO   = 8;
  localparam int unsigned STRAP_PCI_BYP   = 7;
  localparam int unsigned STRAP_SYS_BYP   = 6;
  localparam int unsigned STRAP_IRQ_POL   = 5;
  localparam int unsigned STRAP_RAMCLK_EN = 4;
  localparam int unsigned STRAP_FREEZE    = 3;
  localparam int unsigned STRAP_SIM_FAST  = 2;

  // strap image with every pin left at its pull-up
  localparam logic [15:0] STRAP_RESET = 16'hffff;

  // memory clock rate produced by the clock pad when enabled
  localparam int unsigned RAM_CLK_MHZ = 66;

endpackage

//--- rbc_if.sv
// carriers between the sequencer top and its two helper modules
// assumes all members sit in the reference clock domain
`timescale 1ns/10ps

// one hold-off counter: run level, count tick, short select, done
interface hold_if;
  logic run;
  logic tick;
  logic short;
  logic done;
  modport ctrl (output run, output tick, output short, input done);
  modport cnt  (input run, input tick, input short, output done);
endinterface

// one buffer memory access request from the core
interface mem_if;
  logic             req;
  logic             wr;
  logic [3:0]       be;
  modport core   (output req, output wr, output be);
  modport strobe (input req, input wr, input be);
endinterface

//--- reset_hold.sv
// post-reset hold-off counter for one reset domain
// assumes run drops whenever the domain reset is asserted
`timescale 1ns/10ps
module reset_hold #(
  parameter logic [14:0] HOLD_CYCLES = rbc_pkg::HOLD_LONG
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // control
  hold_if.cnt       hold
);
  import rbc_pkg::*;

  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
    logic              done;
  } hold_s;

  hold_s       st_r;
  hold_s       st_nxt;
  logic [14:0] limit;

  // pick the long or simulation-short count
  assign limit = hold.short ? HOLD_SHORT : HOLD_CYCLES;

  // count ticks while released, restart on every reset
  always_comb begin
    st_nxt = st_r;
    if (!hold.run) begin
      st_nxt.cnt  = '0;
      st_nxt.done = 1'b0;
    end else if (!st_r.done && hold.tick) begin
      if (st_r.cnt + 15'h0001 >= limit) begin
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 15'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hold.done = st_r.done;

endmodule

//--- mem_strobe.sv
// buffer memory strobe drivers, all active low and registered
// assumes the request is only raised while the core is out of reset
`timescale 1ns/10ps
module mem_strobe (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  // request from core
  mem_if.strobe           mem,
  // memory strobes
  output logic            ram_adsc_n_out,
  output logic [3:0]      ram_we_n_out,
  output logic [3:0]      ram_oe_n_out
);
  import rbc_pkg::*;

  typedef struct packed {
    logic       adsc_n;
    logic [3:0] we_n;
    logic [3:0] oe_n;
  } strb_s;

  strb_s st_r;
  strb_s st_nxt;

  // decode request into strobes, one lane per byte enable
  always_comb begin
    st_nxt.adsc_n = ~mem.req;
    st_nxt.we_n   = (mem.req && mem.wr) ? ~mem.be : 4'hf;
    st_nxt.oe_n   = (mem.req && !mem.wr) ? ~mem.be : 4'hf;
  end

  // strobes idle high in reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{adsc_n: 1'b1, we_n: 4'hf, oe_n: 4'hf};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ram_adsc_n_out = st_r.adsc_n;
  assign ram_we_n_out   = st_r.we_n;
  assign ram_oe_n_out   = st_r.oe_n;

endmodule

//--- rbc_top.sv
// reset sequencing and bootstrap strap capture for the bridge core
// assumes arst_n_in is the system reset pin; pci clock and reset,
// test mode and test bus pins are asynchronous and are synchronised
//
// Function
// - phy reset low while system reset low
// - hold core after system reset release
// - hold pci core after pci reset release
// - test mode chosen at reset from selector
// - sample test bus straps after reset, normal
// - drive test mux on bus after sampling
// - straps ten to eight set memory clock delay
// - strap seven low bypasses pci pll
// - strap six low bypasses system pll
// - strap five sets aux interrupt polarity
// - strap four low enables memory clock output
// - strap three low enables freeze
// - strap two low shortens hold to 256
// - memory clock runs 66 MHz, normal mode only
// - drive active-low address status strobe
// - drive four active-low write lane strobes
// - drive four active-low read lane strobes
// - board test holds core, bit ten selects
// - scan mode bypasses plls, passes reset pins
`timescale 1ns/10ps
module rbc_top #(
  parameter logic [14:0] HOLD_CYCLES = rbc_pkg::HOLD_LONG
) (
  // clock and system reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   arst_n_in,
  // pci clock and reset pins
  input  wire logic                   pci_clk_in,
  input  wire logic                   pci_rst_n_in,
  // test mode selector and test bus pins
  input  wire logic [1:0]             t_mode_in,
  input  wire logic [rbc_pkg::TD_W-1:0] t_d_in,
  output logic [rbc_pkg::TD_W-1:0]    t_d_out,
  output logic                        t_d_oe_out,
  // internal test multiplexer source
  input  wire logic [rbc_pkg::TD_W-1:0] test_mux_in,
  // raw active-high auxiliary interrupt events
  input  wire logic                   aux_event_0_in,
  input  wire logic                   aux_event_1_in,
  // core buffer memory request
  input  wire logic                   mem_req_in,
  input  wire logic                   mem_wr_in,
  input  wire logic [3:0]             mem_be_in,
  // resets out
  output logic                        phy_rst_n_out,
  output logic                        sys_core_rst_n_out,
  output logic                        pci_core_rst_n_out,
  // configuration out
  output logic [1:0]                  test_mode_out,
  output logic                        board_test_sel_out,
  output logic                        sys_pll_bypass_out,
  output logic                        pci_pll_bypass_out,
  output logic [2:0]                  ram_clk_dly_out,
  output logic                        ram_clk_oe_out,
  output logic                        freeze_en_out,
  output logic                        straps_valid_out,
  // auxiliary interrupts with strapped polarity
  output logic                        aux_interrupt_0_out,
  output logic                        aux_interrupt_1_out,
  // buffer memory strobes
  output logic                        ram_adsc_n_out,
  output logic [3:0]                  ram_we_n_out,
  output logic [3:0]                  ram_oe_n_out
);
  import rbc_pkg::*;

  typedef struct packed {
    seq_e              seq;
    logic [2:0]        dly;
    logic [1:0]        tm_s1;
    logic [1:0]        tm_s2;
    logic [TD_W-1:0]   td_s1;
    logic [TD_W-1:0]   td_s2;
    logic              prst_s1;
    logic              prst_s2;
    logic              pclk_s1;
    logic              pclk_s2;
    logic              pclk_s3;
    tmode_e            mode;
    logic [TD_W-1:0]   straps;
    logic              phy_rst_n;
    logic              sys_rst_n;
    logic              pci_rst_n;
    logic              td_oe;
    logic [TD_W-1:0]   td_q;
    logic              board_sel;
    logic              sys_byp;
    logic              pci_byp;
    logic [2:0]        cdly;
    logic              ck_oe;
    logic              frz;
    logic              valid;
    logic              aux0;
    logic              aux1;
  } top_s;

  top_s            st_r;
  top_s            st_nxt;
  logic [TD_W-1:0] eff;
  logic            normal;
  logic            sampled;

  hold_if sys_h ();
  hold_if pci_h ();
  mem_if  mem ();

  // straps count only in normal mode, bit ten also in board mode; other modes see the pull-ups
  assign normal  = (st_r.mode == MODE_NORMAL);
  assign eff     = normal ? st_r.straps : STRAP_RESET;
  assign sampled = (st_r.seq == SEQ_HOLD) || (st_r.seq == SEQ_RUN);

  // hold-off counter controls for both reset domains
  assign sys_h.run   = sampled;
  assign sys_h.tick  = 1'b1;
  assign sys_h.short = ~eff[STRAP_SIM_FAST];
  assign pci_h.run   = sampled && st_r.prst_s2;
  assign pci_h.tick  = st_r.pclk_s2 && !st_r.pclk_s3;
  assign pci_h.short = ~eff[STRAP_SIM_FAST];

  // memory requests pass only while the system core runs
  assign mem.req = mem_req_in && st_r.sys_rst_n;
  assign mem.wr  = mem_wr_in;
  assign mem.be  = mem_be_in;

  // sequencer, synchronisers and configuration decode
  always_comb begin
    st_nxt         = st_r;
    st_nxt.tm_s1   = t_mode_in;
    st_nxt.tm_s2   = st_r.tm_s1;
    st_nxt.td_s1   = t_d_in;
    st_nxt.td_s2   = st_r.td_s1;
    st_nxt.prst_s1 = pci_rst_n_in;
    st_nxt.prst_s2 = st_r.prst_s1;
    st_nxt.pclk_s1 = pci_clk_in;
    st_nxt.pclk_s2 = st_r.pclk_s1;
    st_nxt.pclk_s3 = st_r.pclk_s2;
    st_nxt.phy_rst_n = 1'b1;

    unique case (st_r.seq)
      SEQ_WAIT: begin
        if (st_r.dly == STRAP_DLY) begin
          st_nxt.seq = SEQ_SAMPLE;
        end else begin
          st_nxt.dly = st_r.dly + 3'h1;
        end
      end
      SEQ_SAMPLE: begin
        // one capture per release, held until next reset
        st_nxt.mode   = tmode_e'(st_r.tm_s2);
        st_nxt.straps = st_r.td_s2;
        st_nxt.valid  = 1'b1;
        st_nxt.seq    = SEQ_HOLD;
      end
      SEQ_HOLD: begin
        if (sys_h.done || !normal) begin
          st_nxt.seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        st_nxt.seq = SEQ_RUN;
      end
    endcase

    // core resets per test mode
    unique case (st_r.mode)
      MODE_NORMAL: begin
        st_nxt.sys_rst_n = sys_h.done;
        st_nxt.pci_rst_n = pci_h.done;
      end
      MODE_SCAN: begin
        st_nxt.sys_rst_n = sampled;
        st_nxt.pci_rst_n = sampled && st_r.prst_s2;
      end
      MODE_BOARD, MODE_PLL: begin
        st_nxt.sys_rst_n = 1'b0;
        st_nxt.pci_rst_n = 1'b0;
      end
    endcase

    // test bus turns around to the mux once captured
    st_nxt.td_oe = sampled;
    st_nxt.td_q  = sampled ? test_mux_in : '0;

    // strap decode
    st_nxt.board_sel = (st_r.mode == MODE_BOARD) &&
                       st_r.straps[STRAP_BOARD_SEL];
    st_nxt.sys_byp = !eff[STRAP_SYS_BYP] ||
                     (st_r.mode == MODE_SCAN);
    st_nxt.pci_byp = !eff[STRAP_PCI_BYP] ||
                     (st_r.mode == MODE_SCAN);
    st_nxt.cdly  = eff[STRAP_CDLY_HI:STRAP_CDLY_LO];
    st_nxt.ck_oe = sampled && !eff[STRAP_RAMCLK_EN];
    st_nxt.frz   = sampled && !eff[STRAP_FREEZE];

    // interrupt polarity: low strap makes them active low
    st_nxt.aux0 = eff[STRAP_IRQ_POL] ? aux_event_0_in
                                     : ~aux_event_0_in;
    st_nxt.aux1 = eff[STRAP_IRQ_POL] ? aux_event_1_in
                                     : ~aux_event_1_in;
  end

  // state register; phy and core resets low while reset held
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r           <= '0;
      st_r.seq       <= SEQ_WAIT;
      st_r.mode      <= MODE_NORMAL;
      st_r.straps    <= STRAP_RESET;
      st_r.cdly      <= STRAP_RESET[STRAP_CDLY_HI:STRAP_CDLY_LO];
      st_r.phy_rst_n <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // system domain hold-off
  reset_hold #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_sys_hold (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .hold       (sys_h.cnt)
  );

  // pci domain hold-off, counting pci clock edges
  reset_hold #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_pci_hold (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .hold       (pci_h.cnt)
  );

  // buffer memory strobes
  mem_strobe u_strobe (
    .ref_clk_in     (ref_clk_in),
    .arst_n_in      (arst_n_in),
    .mem            (mem.strobe),
    .ram_adsc_n_out (ram_adsc_n_out),
    .ram_we_n_out   (ram_we_n_out),
    .ram_oe_n_out   (ram_oe_n_out)
  );

  // outputs straight from the state register
  assign t_d_out             = st_r.td_q;
  assign t_d_oe_out          = st_r.td_oe;
  assign phy_rst_n_out       = st_r.phy_rst_n;
  assign sys_core_rst_n_out  = st_r.sys_rst_n;
  assign pci_core_rst_n_out  = st_r.pci_rst_n;
  assign test_mode_out       = st_r.mode;
  assign board_test_sel_out  = st_r.board_sel;
  assign sys_pll_bypass_out  = st_r.sys_byp;
  assign pci_pll_bypass_out  = st_r.pci_byp;
  assign ram_clk_dly_out     = st_r.cdly;
  assign ram_clk_oe_out      = st_r.ck_oe;
  assign freeze_en_out       = st_r.frz;
  assign straps_valid_out    = st_r.valid;
  assign aux_interrupt_0_out = st_r.aux0;
  assign aux_interrupt_1_out = st_r.aux1;

endmodule

//--- rbc_checker.sv
// port checker for the reset and bootstrap block
// assumes a bind onto rbc_top and the single reference clock
`timescale 1ns/10ps
module rbc_checker
  import rbc_pkg::*;
#(
  parameter logic [14:0] HOLD_CYCLES = HOLD_LONG
) (
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  // inputs seen by the block
  input wire logic       mem_req_in,
  input wire logic       mem_wr_in,
  input wire logic [3:0] mem_be_in,
  input wire logic       aux_event_0_in,
  input wire logic       aux_event_1_in,
  // outputs of the block
  input wire logic       phy_rst_n_out,
  input wire logic       sys_core_rst_n_out,
  input wire logic       pci_core_rst_n_out,
  input wire logic [1:0] test_mode_out,
  input wire logic       sys_pll_bypass_out,
  input wire logic       pci_pll_bypass_out,
  input wire logic       ram_clk_oe_out,
  input wire logic       straps_valid_out,
  input wire logic       t_d_oe_out,
  input wire logic       aux_interrupt_0_out,
  input wire logic       aux_interrupt_1_out,
  input wire logic       ram_adsc_n_out,
  input wire logic [3:0] ram_we_n_out,
  input wire logic [3:0] ram_oe_n_out
);
  import rbc_pkg::*;
  logic [15:0] hold_cnt_r;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // cycles from strap capture until the core leaves reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) hold_cnt_r <= 16'h0000;
    else if (straps_valid_out && !sys_core_rst_n_out)
      hold_cnt_r <= hold_cnt_r + 16'h0001;
  end
  // phy reset steps after reset release
  sequence s_release; $rose(arst_n_in); endsequence
  sequence s_phy_up; !phy_rst_n_out ##[1:3] phy_rst_n_out; endsequence
  a_phy_release: assert property (s_release |-> s_phy_up)
    else $error("phy reset not released after system reset");
  a_phy_stays: assert property (phy_rst_n_out |=> phy_rst_n_out)
    else $error("phy reset dropped without system reset");
  a_core_early: assert property (!straps_valid_out |->
    !sys_core_rst_n_out && !pci_core_rst_n_out && !t_d_oe_out)
    else $error("core or bus active before strap capture");
  a_hold_length: assert property ($rose(sys_core_rst_n_out) &&
    test_mode_out == MODE_NORMAL |-> hold_cnt_r >= 16'h00fe &&
    hold_cnt_r <= {1'b0, HOLD_CYCLES} + 16'h0004)
    else $error("system core hold length out of range");
  a_held_modes: assert property (straps_valid_out &&
    test_mode_out inside {MODE_PLL, MODE_BOARD} |->
    !sys_core_rst_n_out && !pci_core_rst_n_out)
    else $error("core released in a held test mode");
  a_scan_bypass: assert property ($rose(straps_valid_out) &&
    test_mode_out == MODE_SCAN |-> ##[1:2]
    (sys_pll_bypass_out && pci_pll_bypass_out && sys_core_rst_n_out))
    else $error("scan mode did not bypass plls");
  a_idle_strobe: assert property (!sys_core_rst_n_out |=>
    ram_adsc_n_out && ram_we_n_out == 4'hf && ram_oe_n_out == 4'hf)
    else $error("memory strobe active in core reset");
  a_write_lanes: assert property (sys_core_rst_n_out && mem_req_in &&
    mem_wr_in |=> !ram_adsc_n_out && ram_oe_n_out == 4'hf &&
    ram_we_n_out == ~$past(mem_be_in))
    else $error("write lane strobes wrong");
  a_read_lanes: assert property (sys_core_rst_n_out && mem_req_in &&
    !mem_wr_in |=> !ram_adsc_n_out && ram_we_n_out == 4'hf &&
    ram_oe_n_out == ~$past(mem_be_in))
    else $error("read lane strobes wrong");
  a_aux_pol: assert property ($past(straps_valid_out, 2) |->
    (aux_interrupt_0_out ^ $past(aux_event_0_in)) ==
    (aux_interrupt_1_out ^ $past(aux_event_1_in)))
    else $error("aux interrupt polarities differ");
  a_memclk_mode: assert property (ram_clk_oe_out |->
    test_mode_out == MODE_NORMAL)
    else $error("memory clock enabled outside normal mode");
endmodule
bind rbc_top rbc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
  .ref_clk_in (ref_clk_in), .arst_n_in (arst_n_in),
  .mem_req_in (mem_req_in), .mem_wr_in (mem_wr_in),
  .mem_be_in (mem_be_in), .aux_event_0_in (aux_event_0_in),
  .aux_event_1_in (aux_event_1_in), .phy_rst_n_out (phy_rst_n_out),
  .sys_core_rst_n_out (sys_core_rst_n_out),
  .pci_core_rst_n_out (pci_core_rst_n_out),
  .test_mode_out (test_mode_out),
  .sys_pll_bypass_out (sys_pll_bypass_out),
  .pci_pll_bypass_out (pci_pll_bypass_out),
  .ram_clk_oe_out (ram_clk_oe_out), .straps_valid_out (straps_valid_out),
  .t_d_oe_out (t_d_oe_out), .aux_interrupt_0_out (aux_interrupt_0_out),
  .aux_interrupt_1_out (aux_interrupt_1_out),
  .ram_adsc_n_out (ram_adsc_n_out), .ram_we_n_out (ram_we_n_out),
  .ram_oe_n_out (ram_oe_n_out)
);

//--- board_model.sv
// board straps, pull-ups and pci host reset around the block
// assumes the bench sets pull-downs, mode pins and pci reset
`timescale 1ns/10ps
module board_model
  import rbc_pkg::*;
(
  // bench controls
  input  wire logic [TD_W-1:0] pull_low_in,
  input  wire logic [1:0]      mode_in,
  input  wire logic            pci_hold_n_in,
  // device drive onto the test bus
  input  wire logic [TD_W-1:0] drive_in,
  input  wire logic            drive_oe_in,
  // pins toward the device
  output logic                 pci_clk_out,
  output logic                 pci_rst_n_out,
  output logic [1:0]           t_mode_out,
  output logic [TD_W-1:0]      t_d_wire_out,
  output logic                 jtag_trst_n_out
);
  logic [TD_W-1:0] pulls;
  // free running 5 MHz pci clock, offset from the reference
  initial begin
    pci_clk_out = 1'b0;
    #7;
    forever #100 pci_clk_out = ~pci_clk_out;
  end
  // pci reset changes only on a pci clock edge
  always @(posedge pci_clk_out) pci_rst_n_out <= pci_hold_n_in;
  // bit fourteen pulled low in normal mode, the rest open
  assign pulls = pull_low_in |
    ((mode_in == MODE_NORMAL) ? 16'h4000 : 16'h0000);
  // released pins float to their pull-ups
  assign t_d_wire_out = drive_oe_in ? drive_in : ~pulls;
  assign t_mode_out = mode_in;
  assign jtag_trst_n_out = 1'b0;
endmodule

//--- rbc_top_tb_top.sv
// self-checking bench for the reset and bootstrap block
// assumes board_model on the pins and the bound checker
`timescale 1ns/10ps
module rbc_top_tb_top;
  import rbc_pkg::*;
  localparam logic [14:0] HOLD = 15'h012c; // 300 cycles
  logic ref_clk_in, arst_n_in, aux_event_0_in, aux_event_1_in;
  logic mem_req_in, mem_wr_in, pci_hold_n, pci_clk_in, pci_rst_n_in;
  logic [3:0] mem_be_in, ram_we_n_out, ram_oe_n_out;
  logic [1:0] mode, t_mode_in, test_mode_out;
  logic [TD_W-1:0] pull_low, t_d_in, t_d_out, test_mux_in;
  logic [2:0] ram_clk_dly_out;
  logic t_d_oe_out, phy_rst_n_out, sys_core_rst_n_out, pci_core_rst_n_out;
  logic board_test_sel_out, sys_pll_bypass_out, pci_pll_bypass_out;
  logic ram_clk_oe_out, freeze_en_out, straps_valid_out, ram_adsc_n_out;
  logic aux_interrupt_0_out, aux_interrupt_1_out;
  int   mismatches, n_checks;
  time  t_valid;
  board_model brd_u (
    .pull_low_in     (pull_low),
    .mode_in         (mode),
    .pci_hold_n_in   (pci_hold_n),
    .drive_in        (t_d_out),
    .drive_oe_in     (t_d_oe_out),
    .pci_clk_out     (pci_clk_in),
    .pci_rst_n_out   (pci_rst_n_in),
    .t_mode_out      (t_mode_in),
    .t_d_wire_out    (t_d_in),
    .jtag_trst_n_out ()
  );
  rbc_top #(.HOLD_CYCLES(HOLD)) dut_u (
    .ref_clk_in (ref_clk_in), .arst_n_in (arst_n_in),
    .pci_clk_in (pci_clk_in), .pci_rst_n_in (pci_rst_n_in),
    .t_mode_in (t_mode_in), .t_d_in (t_d_in), .t_d_out (t_d_out),
    .t_d_oe_out (t_d_oe_out), .test_mux_in (test_mux_in),
    .aux_event_0_in (aux_event_0_in), .aux_event_1_in (aux_event_1_in),
    .mem_req_in (mem_req_in), .mem_wr_in (mem_wr_in),
    .mem_be_in (mem_be_in), .phy_rst_n_out (phy_rst_n_out),
    .sys_core_rst_n_out (sys_core_rst_n_out),
    .pci_core_rst_n_out (pci_core_rst_n_out),
    .test_mode_out (test_mode_out),
    .board_test_sel_out (board_test_sel_out),
    .sys_pll_bypass_out (sys_pll_bypass_out),
    .pci_pll_bypass_out (pci_pll_bypass_out),
    .ram_clk_dly_out (ram_clk_dly_out), .ram_clk_oe_out (ram_clk_oe_out),
    .freeze_en_out (freeze_en_out), .straps_valid_out (straps_valid_out),
    .aux_interrupt_0_out (aux_interrupt_0_out),
    .aux_interrupt_1_out (aux_interrupt_1_out),
    .ram_adsc_n_out (ram_adsc_n_out), .ram_we_n_out (ram_we_n_out),
    .ram_oe_n_out (ram_oe_n_out)
  );
  // reference clock
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // compare a design value
  task automatic chk(input logic [15:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // compare a counted figure against a window
  task automatic chk_cnt(input int got, lo, hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR %0t %s count %0d", $time, what, got);
    end
  endtask
  // bounded wait for a signal to go high
  task automatic wait_hi(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1) begin
      @(negedge ref_clk_in);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("ERROR %0t wait timed out", $time);
        end_sim();
      end
    end
  endtask
  // reset with given pull-downs and mode, then wait for capture
  task automatic boot(input logic [15:0] pl, input logic [1:0] md);
    pull_low = pl;
    mode = md;
    pci_hold_n = 1'b0;
    arst_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk(phy_rst_n_out, 1'b0, "phy in reset");
    arst_n_in = 1'b1;
    wait_hi(straps_valid_out, 20);
    t_valid = $time;
    chk(phy_rst_n_out, 1'b1, "phy released");
    chk(test_mode_out, md, "mode");
    repeat (2) @(negedge ref_clk_in);
  endtask
  // count pci edges until the pci core leaves reset
  task automatic pci_hold(input int lim);
    int n, k;
    logic p;
    pci_hold_n = 1'b1;
    n = 0;
    k = 0;
    p = pci_clk_in;
    while (pci_core_rst_n_out !== 1'b1 && k < 12 * lim) begin
      @(negedge ref_clk_in);
      k++;
      if (pci_clk_in && !p && pci_rst_n_in) n++;
      p = pci_clk_in;
    end
    if (pci_core_rst_n_out !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t pci hold timed out", $time);
      end_sim();
    end
    chk_cnt(n, lim - 1, lim + 3, "pci hold");
  endtask
  // one memory request, strobes judged one cycle later
  task automatic mem_op(input logic rq, wr, input logic [3:0] be,
                        input logic [8:0] exp);
    mem_req_in = rq;
    mem_wr_in = wr;
    mem_be_in = be;
    @(negedge ref_clk_in);
    chk({ram_adsc_n_out, ram_we_n_out, ram_oe_n_out}, exp, "strobes");
  endtask
  // all straps open: defaults, mux drive, long holds
  task automatic t_normal_default();
    boot(16'h0000, MODE_NORMAL);
    chk({sys_pll_bypass_out, pci_pll_bypass_out, ram_clk_oe_out,
         freeze_en_out}, 4'h0, "cfg open");
    chk(ram_clk_dly_out, 3'h7, "delay open");
    chk(t_d_oe_out, 1'b1, "bus drive");
    test_mux_in = 16'h5a3c;
    aux_event_0_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk(t_d_out, 16'h5a3c, "mux out");
    chk({aux_interrupt_1_out, aux_interrupt_0_out}, 2'h1, "aux");
    wait_hi(sys_core_rst_n_out, 400);
    chk_cnt(int'(($time - t_valid) / 20), HOLD - 1, HOLD + 2, "sys");
    pci_hold(HOLD);
  endtask
  // straps pulled low: config, latching, short holds, strobes
  task automatic t_normal_straps();
    boot(16'h05fc, MODE_NORMAL);
    chk({sys_pll_bypass_out, pci_pll_bypass_out, ram_clk_oe_out,
         freeze_en_out}, 4'hf, "cfg low");
    chk(ram_clk_dly_out, 3'h2, "delay");
    pull_low = 16'h0000;
    test_mux_in = 16'hffff;
    aux_event_0_in = 1'b0;
    aux_event_1_in = 1'b1;
    mem_op(1'b1, 1'b1, 4'h3, 9'h1ff);
    chk(ram_clk_dly_out, 3'h2, "delay held");
    chk({aux_interrupt_1_out, aux_interrupt_0_out}, 2'h1, "aux");
    mem_req_in = 1'b0;
    wait_hi(sys_core_rst_n_out, 400);
    chk_cnt(int'(($time - t_valid) / 20), 255, 258, "sys short");
    chk(ram_clk_dly_out, 3'h2, "delay late");
    chk({sys_pll_bypass_out, pci_pll_bypass_out, ram_clk_oe_out,
         freeze_en_out}, 4'hf, "cfg held");
    mem_op(1'b1, 1'b1, 4'h3, 9'h0cf);
    mem_op(1'b1, 1'b0, 4'ha, 9'h0f5);
    mem_op(1'b1, 1'b1, 4'hf, 9'h00f);
    mem_op(1'b0, 1'b0, 4'h0, 9'h1ff);
    pci_hold(256);
  endtask
  // scan mode passes resets straight through
  task automatic t_scan();
    boot(16'h0000, MODE_SCAN);
    chk({sys_pll_bypass_out, pci_pll_bypass_out}, 2'h3, "bypass");
    wait_hi(sys_core_rst_n_out, 8);
    pci_hold_n = 1'b1;
    wait_hi(pci_core_rst_n_out, 40);
  endtask
  // board and pll modes keep the core in reset
  task automatic t_held_modes();
    for (int i = 0; i < 2; i++) begin
      boot(16'h0000, i ? MODE_PLL : MODE_BOARD);
      chk(board_test_sel_out, i == 0, "board select");
      pci_hold_n = 1'b1;
      repeat (600) @(negedge ref_clk_in);
      chk({sys_core_rst_n_out, pci_core_rst_n_out}, 2'h0, "held");
    end
  endtask
  // main sequence
  initial begin
    arst_n_in = 1'b0;
    mem_req_in = 1'b0;
    mem_wr_in = 1'b0;
    mem_be_in = 4'h0;
    test_mux_in = 16'h0000;
    aux_event_0_in = 1'b0;
    aux_event_1_in = 1'b0;
    pull_low = 16'h0000;
    mode = MODE_NORMAL;
    pci_hold_n = 1'b0;
    #5;
    t_normal_default();
    t_normal_straps();
    t_scan();
    t_held_modes();
    end_sim();
  end
endmodule
